// [rtl/rcc_regs.sv]
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rcc_regs #(
	parameter logic [7:0] CORE_TYPE = 8'h01, // Arbitrary identity value
	parameter logic [7:0] MAJOR_RELEASE = 8'h00,
	parameter logic [7:0] UPGRADE_NUMBER = 8'h00,
	parameter logic [7:0] BUILD_NUMBER = 8'h00,
	parameter int PTR_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic initiator_i,
	input wire logic tx_sn_desc_i,
	input wire logic tx_nesn_desc_i,
	input wire logic tx_sn_hw_i,
	input wire logic tx_nesn_hw_i,
	input wire logic rx_sn_err_i,
	input wire logic conn_cipher_enable_i,
	input wire logic [15:0] tx_winoff_buf_i,
	input wire logic [15:0] tx_winoff_evt_i,
	input wire logic [PTR_W-1:0] cs_rx_ptr_i,
	input wire logic [PTR_W-1:0] current_rx_descriptor_ptr_i,
	input wire logic [15:0] tx_crc_i,
	input wire logic adv_channel_i,
	input wire logic rx_error_i,
	input wire logic rx_done_i,
	input wire logic coex_pulse_req_i,
	input wire logic event_start_i,
	input wire logic more_data_rx_i,
	output logic tx_sn_o,
	output logic tx_nesn_o,
	output logic seq_err_o,
	output logic cipher_payload_o,
	output logic integrity_check_value_gen_o,
	output logic [15:0] tx_winoff_o,
	output logic [PTR_W-1:0] rx_ptr_o,
	output logic [15:0] tx_crc_o,
	output logic rx_report_o,
	output logic more_data_disable_o,
	output logic whitening_enable_o,
	output logic checksum_strip_o,
	output logic channel_remap_enable_o,
	output logic coex_sync_pulse_o,
	output logic exchange_prefetch_enable_o,
	output logic [3:0] default_rx_window_o,
	output logic [2:0] sync_word_error_limit_o,
	output logic exchange_allowed_o
);
	// ****************************************
	// Bus decode
	// ****************************************
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] rdata_d;
	logic ex_done_q;
	wire logic setup = psel_i & ~penable_i;
	wire logic hit_ctrl = (paddr_i == rcc_pkg::CONTROL_ADDR);
	wire logic hit_ver = (paddr_i == rcc_pkg::VERSION_ADDR);
	wire logic mapped = hit_ctrl | hit_ver;
	wire logic wr_ctrl = psel_i & penable_i & pwrite_i & hit_ctrl;
	wire logic [31:0] version_word = {CORE_TYPE, MAJOR_RELEASE, UPGRADE_NUMBER, BUILD_NUMBER};

	// Byte-lane merge of a write
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign ctrl_d = lane_merge(ctrl_q, pwdata_i, pstrb_i) & rcc_pkg::CONTROL_WMASK;
	assign rdata_d = hit_ctrl ? ctrl_q : (hit_ver ? version_word : rcc_pkg::UNMAPPED_DATA);

	// Zero wait states: ready registered from setup, high in the access phase so that phase completes in one cycle
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= setup;
			pslverr_o <= setup & ~mapped;
			prdata_o <= (setup & ~pwrite_i) ? rdata_d : 32'h0000_0000;
		end
	end

	// Control register; writes to version are silently dropped
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= rcc_pkg::CONTROL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// Control fields to the core
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			more_data_disable_o <= 1'b0;
			whitening_enable_o <= 1'b0;
			checksum_strip_o <= 1'b0;
			channel_remap_enable_o <= 1'b0;
			coex_sync_pulse_o <= 1'b0;
			exchange_prefetch_enable_o <= 1'b0;
			default_rx_window_o <= 4'h0;
			sync_word_error_limit_o <= 3'h0;
		end else begin
			more_data_disable_o <= ctrl_q[rcc_pkg::MORE_DATA_DIS_BIT];
			whitening_enable_o <= ~ctrl_q[rcc_pkg::WHITEN_DIS_BIT];
			checksum_strip_o <= ~ctrl_q[rcc_pkg::CHECKSUM_DIS_BIT];
			channel_remap_enable_o <= ~ctrl_q[rcc_pkg::REMAP_DIS_BIT];
			coex_sync_pulse_o <= coex_pulse_req_i & ctrl_q[rcc_pkg::COEX_EN_BIT];
			exchange_prefetch_enable_o <= ctrl_q[rcc_pkg::PREFETCH_EN_BIT];
			default_rx_window_o <= ctrl_q[rcc_pkg::RXWIN_LSB +: rcc_pkg::RXWIN_W];
			sync_word_error_limit_o <= ctrl_q[rcc_pkg::SYNC_WORD_ERROR_LIMIT_LSB +: rcc_pkg::SYNC_WORD_ERROR_LIMIT_W];
		end
	end

	// ****************************************
	// Exchange limiter
	// ****************************************
	// single exchange when more-data disabled
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ex_done_q <= 1'b0;
		end else if (event_start_i) begin
			ex_done_q <= 1'b0;
		end else if (rx_done_i) begin
			ex_done_q <= 1'b1;
		end
	end

	// Further exchanges only while more data flagged and not disabled
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			exchange_allowed_o <= 1'b0;
		end else begin
			exchange_allowed_o <= event_start_i | ~ex_done_q |
				(more_data_rx_i & ~ctrl_q[rcc_pkg::MORE_DATA_DIS_BIT]);
		end
	end

	// ****************************************
	// Packet steering
	// ****************************************
	rcc_datapath #(
		.PTR_W(PTR_W)
	) i_rcc_datapath (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.ctrl_i(ctrl_q),
		.initiator_i(initiator_i),
		.tx_sn_desc_i(tx_sn_desc_i),
		.tx_nesn_desc_i(tx_nesn_desc_i),
		.tx_sn_hw_i(tx_sn_hw_i),
		.tx_nesn_hw_i(tx_nesn_hw_i),
		.rx_sn_err_i(rx_sn_err_i),
		.conn_cipher_enable_i(conn_cipher_enable_i),
		.tx_winoff_buf_i(tx_winoff_buf_i),
		.tx_winoff_evt_i(tx_winoff_evt_i),
		.cs_rx_ptr_i(cs_rx_ptr_i),
		.current_rx_descriptor_ptr_i(current_rx_descriptor_ptr_i),
		.tx_crc_i(tx_crc_i),
		.adv_channel_i(adv_channel_i),
		.rx_error_i(rx_error_i),
		.rx_done_i(rx_done_i),
		.tx_sn_o(tx_sn_o),
		.tx_nesn_o(tx_nesn_o),
		.seq_err_o(seq_err_o),
		.cipher_payload_o(cipher_payload_o),
		.integrity_check_value_gen_o(integrity_check_value_gen_o),
		.tx_winoff_o(tx_winoff_o),
		.rx_ptr_o(rx_ptr_o),
		.tx_crc_o(tx_crc_o),
		.rx_report_o(rx_report_o)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ctrl_q & ~rcc_pkg::CONTROL_WMASK) == 32'h0000_0000)
		else $error("reserved control bit set");
	a_version_read: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		setup & ~pwrite_i & hit_ver |=> prdata_o == version_word)
		else $error("version read wrong");
	a_ctrl_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		wr_ctrl |=> ctrl_q == $past(ctrl_d))
		else $error("control write lost");
	a_seq_err_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(ctrl_q[rcc_pkg::SEQNUM_DIS_BIT] | ctrl_q[rcc_pkg::NESN_DIS_BIT]) ##1
		$stable(ctrl_q) |-> !seq_err_o)
		else $error("sequence error while disabled");
	a_sn_from_desc: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ctrl_q[rcc_pkg::SEQNUM_DIS_BIT] |=> tx_sn_o == $past(tx_sn_desc_i))
		else $error("sn not from descriptor");
	a_cipher_bypass: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ctrl_q[rcc_pkg::CIPHER_DIS_BIT] & conn_cipher_enable_i |=>
		!cipher_payload_o && integrity_check_value_gen_o)
		else $error("cipher bypass wrong");
	a_crc_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ctrl_q[rcc_pkg::CHECKSUM_DIS_BIT] |=> tx_crc_o == 16'h0000 && !checksum_strip_o)
		else $error("checksum not zeroed");
	a_winoff_evt: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		initiator_i & ctrl_q[rcc_pkg::WINOFF_SEL_BIT] |=> tx_winoff_o == $past(tx_winoff_evt_i))
		else $error("window offset source wrong");
	a_coex_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		!ctrl_q[rcc_pkg::COEX_EN_BIT] |=> !coex_sync_pulse_o)
		else $error("coex pulse while disabled");
	a_adv_filter: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		adv_channel_i & rx_error_i & ctrl_q[rcc_pkg::ADV_FILT_BIT] |=> !rx_report_o)
		else $error("filtered error reported");
endmodule
`default_nettype wire

// [rtl/rcc_pkg.sv]
package rcc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] CONTROL_ADDR = 32'h4000_0000;
	localparam logic [31:0] VERSION_ADDR = 32'h4000_0004;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL_WMASK = 32'h007f_1ff7;
	// ****************************************
	// Control field positions
	// ****************************************
	localparam int MORE_DATA_DIS_BIT = 22;
	localparam int SEQNUM_DIS_BIT = 21;
	localparam int NESN_DIS_BIT = 20;
	localparam int CIPHER_DIS_BIT = 19;
	localparam int WHITEN_DIS_BIT = 18;
	localparam int CHECKSUM_DIS_BIT = 17;
	localparam int REMAP_DIS_BIT = 16;
	localparam int WINOFF_SEL_BIT = 12;
	localparam int RXPTR_SEL_BIT = 11;
	localparam int ADV_FILT_BIT = 10;
	localparam int COEX_EN_BIT = 9;
	localparam int PREFETCH_EN_BIT = 8;
	localparam int RXWIN_LSB = 4;
	localparam int RXWIN_W = 4;
	localparam int SYNC_WORD_ERROR_LIMIT_LSB = 0;
	localparam int SYNC_WORD_ERROR_LIMIT_W = 3;
	// ****************************************
	// Version field positions and fixed data values
	// ****************************************
	localparam int TYPE_LSB = 24;
	localparam int MAJOR_LSB = 16;
	localparam int UPGRADE_LSB = 8;
	localparam int BUILD_LSB = 0;
	localparam logic [15:0] CHECKSUM_ZERO = 16'h0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// [rtl/rcc_datapath.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Per-packet protocol steering from control
// ****************************************
module rcc_datapath #(
	parameter int PTR_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [31:0] ctrl_i,
	input wire logic initiator_i,
	input wire logic tx_sn_desc_i,
	input wire logic tx_nesn_desc_i,
	input wire logic tx_sn_hw_i,
	input wire logic tx_nesn_hw_i,
	input wire logic rx_sn_err_i,
	input wire logic conn_cipher_enable_i,
	input wire logic [15:0] tx_winoff_buf_i,
	input wire logic [15:0] tx_winoff_evt_i,
	input wire logic [PTR_W-1:0] cs_rx_ptr_i,
	input wire logic [PTR_W-1:0] current_rx_descriptor_ptr_i,
	input wire logic [15:0] tx_crc_i,
	input wire logic adv_channel_i,
	input wire logic rx_error_i,
	input wire logic rx_done_i,
	output logic tx_sn_o,
	output logic tx_nesn_o,
	output logic seq_err_o,
	output logic cipher_payload_o,
	output logic integrity_check_value_gen_o,
	output logic [15:0] tx_winoff_o,
	output logic [PTR_W-1:0] rx_ptr_o,
	output logic [15:0] tx_crc_o,
	output logic rx_report_o
);
	wire logic sn_dis = ctrl_i[rcc_pkg::SEQNUM_DIS_BIT];
	wire logic nesn_dis = ctrl_i[rcc_pkg::NESN_DIS_BIT];
	wire logic cip_dis = ctrl_i[rcc_pkg::CIPHER_DIS_BIT];
	wire logic crc_dis = ctrl_i[rcc_pkg::CHECKSUM_DIS_BIT];
	wire logic use_evt = initiator_i & ctrl_i[rcc_pkg::WINOFF_SEL_BIT];
	wire logic filt = ctrl_i[rcc_pkg::ADV_FILT_BIT];
	wire logic sn_d = sn_dis ? tx_sn_desc_i : tx_sn_hw_i;
	wire logic nesn_d = nesn_dis ? tx_nesn_desc_i : tx_nesn_hw_i;
	wire logic serr_d = rx_sn_err_i & ~(sn_dis | nesn_dis);
	wire logic [15:0] woff_d = use_evt ? tx_winoff_evt_i : tx_winoff_buf_i;
	wire logic [PTR_W-1:0] ptr_d =
		ctrl_i[rcc_pkg::RXPTR_SEL_BIT] ? current_rx_descriptor_ptr_i : cs_rx_ptr_i;
	wire logic [15:0] crc_d = crc_dis ? rcc_pkg::CHECKSUM_ZERO : tx_crc_i;
	wire logic rep_d = rx_done_i & ~(adv_channel_i & filt & rx_error_i);

	// Registered outputs, one stage
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_sn_o <= 1'b0;
			tx_nesn_o <= 1'b0;
			seq_err_o <= 1'b0;
			cipher_payload_o <= 1'b0;
			integrity_check_value_gen_o <= 1'b0;
			tx_winoff_o <= 16'h0000;
			rx_ptr_o <= '0;
			tx_crc_o <= 16'h0000;
			rx_report_o <= 1'b0;
		end else begin
			tx_sn_o <= sn_d;
			tx_nesn_o <= nesn_d;
			seq_err_o <= serr_d;
			cipher_payload_o <= conn_cipher_enable_i & ~cip_dis;
			integrity_check_value_gen_o <= conn_cipher_enable_i;
			tx_winoff_o <= woff_d;
			rx_ptr_o <= ptr_d;
			tx_crc_o <= crc_d;
			rx_report_o <= rep_d;
		end
	end
endmodule
`default_nettype wire

// [bench/tb_rcc_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_rcc_regs;
	// Arbitrary identity value, packed as type/major/upgrade/build
	localparam logic [31:0] VER = 32'h5a12_3456;
	localparam logic [31:0] CA = rcc_pkg::CONTROL_ADDR;
	localparam logic [31:0] VA = rcc_pkg::VERSION_ADDR;
	localparam logic [31:0] WM = rcc_pkg::CONTROL_WMASK;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0;
	logic [3:0] pstrb_i = 4'h0;
	// Descriptor and hardware bits differ so every select is visible
	logic initiator_i = 1'b1, tx_sn_desc_i = 1'b1, tx_nesn_desc_i = 1'b0;
	logic tx_sn_hw_i = 1'b0, tx_nesn_hw_i = 1'b1, rx_sn_err_i = 1'b1;
	logic conn_cipher_enable_i = 1'b1, adv_channel_i = 1'b1, rx_error_i = 1'b1;
	logic rx_done_i = 1'b1, coex_pulse_req_i = 1'b1, event_start_i = 1'b0, more_data_rx_i = 1'b1;
	logic [15:0] tx_winoff_buf_i = 16'h1111, tx_winoff_evt_i = 16'h2222, tx_crc_i = 16'hbeef;
	logic [15:0] cs_rx_ptr_i = 16'h0a0a, current_rx_descriptor_ptr_i = 16'h0b0b;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, tx_sn_o, tx_nesn_o, seq_err_o, cipher_payload_o;
	logic integrity_check_value_gen_o, rx_report_o, more_data_disable_o, whitening_enable_o;
	logic checksum_strip_o, channel_remap_enable_o, coex_sync_pulse_o;
	logic exchange_prefetch_enable_o, exchange_allowed_o;
	logic [15:0] tx_winoff_o, rx_ptr_o, tx_crc_o;
	logic [3:0] default_rx_window_o;
	logic [2:0] sync_word_error_limit_o;
	int n_fail = 0;
	int n_checks = 0;
	// window field never zero in this table
	logic [31:0] tbl [4] = '{32'hffff_ffff, 32'h0055_0aa5, 32'h002a_1552, 32'h0000_00a0};

	// Free-running bench clock
	always #20 ref_clk_i = ~ref_clk_i;

	rcc_regs #(.CORE_TYPE(8'h5a), .MAJOR_RELEASE(8'h12), .UPGRADE_NUMBER(8'h34),
		.BUILD_NUMBER(8'h56), .PTR_W(16)) i_rcc_regs (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.initiator_i(initiator_i), .tx_sn_desc_i(tx_sn_desc_i), .tx_nesn_desc_i(tx_nesn_desc_i),
		.tx_sn_hw_i(tx_sn_hw_i), .tx_nesn_hw_i(tx_nesn_hw_i), .rx_sn_err_i(rx_sn_err_i),
		.conn_cipher_enable_i(conn_cipher_enable_i), .tx_winoff_buf_i(tx_winoff_buf_i),
		.tx_winoff_evt_i(tx_winoff_evt_i), .cs_rx_ptr_i(cs_rx_ptr_i),
		.current_rx_descriptor_ptr_i(current_rx_descriptor_ptr_i), .tx_crc_i(tx_crc_i),
		.adv_channel_i(adv_channel_i), .rx_error_i(rx_error_i), .rx_done_i(rx_done_i),
		.coex_pulse_req_i(coex_pulse_req_i), .event_start_i(event_start_i),
		.more_data_rx_i(more_data_rx_i), .tx_sn_o(tx_sn_o), .tx_nesn_o(tx_nesn_o),
		.seq_err_o(seq_err_o), .cipher_payload_o(cipher_payload_o),
		.integrity_check_value_gen_o(integrity_check_value_gen_o), .tx_winoff_o(tx_winoff_o),
		.rx_ptr_o(rx_ptr_o), .tx_crc_o(tx_crc_o), .rx_report_o(rx_report_o),
		.more_data_disable_o(more_data_disable_o), .whitening_enable_o(whitening_enable_o),
		.checksum_strip_o(checksum_strip_o), .channel_remap_enable_o(channel_remap_enable_o),
		.coex_sync_pulse_o(coex_sync_pulse_o),
		.exchange_prefetch_enable_o(exchange_prefetch_enable_o),
		.default_rx_window_o(default_rx_window_o),
		.sync_word_error_limit_o(sync_word_error_limit_o),
		.exchange_allowed_o(exchange_allowed_o)
	);

	// ****************************************
	// Reporting
	// ****************************************
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	// ****************************************
	// Bus access
	// ****************************************
	// Ready is sampled at the rising edge; request held until that edge, then released
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge ref_clk_i);
			if (pready_o === 1'b1) break;
		end
		r = prdata_o;
		e = pslverr_o;
		if (k == 16) begin
			n_fail++;
			$display("mismatch at %0t: no ready", $time);
			end_sim;
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
		chk(e, xe, "write error flag");
	endtask

	task rd(input logic [31:0] a, input logic [31:0] x, input logic xe, input string m);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, 4'h0, r, e);
		chk({e, r}, {xe, x}, m);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Program control, then compare every steering output against its fields
	task steer(input logic [31:0] c);
		logic [15:0] wo;
		wr(CA, c, 4'hf, 1'b0);
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		wo = (initiator_i && c[12]) ? tx_winoff_evt_i : tx_winoff_buf_i;
		chk({exchange_allowed_o, more_data_disable_o}, {~c[22], c[22]}, "more data");
		chk({tx_sn_o, tx_nesn_o}, {c[21], ~c[20]}, "sequence bits");
		chk(seq_err_o, {~(c[21] | c[20])}, "sequence error");
		chk({cipher_payload_o, integrity_check_value_gen_o}, {~c[19], 1'b1}, "cipher");
		chk(whitening_enable_o, {~c[18]}, "whitening");
		chk({checksum_strip_o, tx_crc_o}, {~c[17], c[17] ? 16'h0000 : tx_crc_i}, "crc");
		chk(channel_remap_enable_o, {~c[16]}, "remap");
		chk(tx_winoff_o, wo, "window offset");
		chk(rx_ptr_o, c[11] ? current_rx_descriptor_ptr_i : cs_rx_ptr_i, "rx pointer");
		chk(rx_report_o, {~c[10]}, "adv filter");
		chk({coex_sync_pulse_o, exchange_prefetch_enable_o}, {c[9], c[8]}, "enables");
		chk(default_rx_window_o, c[7:4], "rx window");
		chk(sync_word_error_limit_o, c[2:0], "sync errors");
		rd(CA, c & WM, 1'b0, "control readback");
	endtask

	// One event, one receipt with more data pending
	task xchg(input logic dis, input logic x);
		wr(CA, {9'h0, dis, 22'h0000a0}, 4'hf, 1'b0);
		@(posedge ref_clk_i);
		rx_done_i <= 1'b0;
		event_start_i <= 1'b1;
		@(posedge ref_clk_i);
		event_start_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk(exchange_allowed_o, 1'b1, "exchange open");
		@(posedge ref_clk_i);
		rx_done_i <= 1'b1;
		@(posedge ref_clk_i);
		rx_done_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk(exchange_allowed_o, x, "exchange after rx");
		@(posedge ref_clk_i);
		rx_done_i <= 1'b1;
	endtask

	initial begin
		repeat (5) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(CA, 32'h0, 1'b0, "control reset");
		rd(VA, VER, 1'b0, "version");
		wr(VA, 32'hffff_ffff, 4'hf, 1'b0);
		rd(VA, VER, 1'b0, "version after write");
		$display("test reset_version done");
		// Unmapped place must not disturb control
		wr(32'h4000_0008, 32'hffff_ffff, 4'hf, 1'b1);
		rd(32'h4000_0008, 32'h0, 1'b1, "unmapped read");
		rd(CA, 32'h0, 1'b0, "control untouched");
		$display("test unmapped done");
		// Second pass outside initiator mode: offset select must be ignored
		for (int p = 0; p < 2; p++) begin
			initiator_i <= (p == 0);
			for (int i = 0; i < 4; i++) begin
				steer(tbl[i]);
			end
		end
		$display("test steering done");
		wr(CA, 32'hffff_ffff, 4'b0001, 1'b0);
		rd(CA, 32'h0000_00f7, 1'b0, "low lane only");
		wr(CA, 32'hffff_ffff, 4'b0100, 1'b0);
		rd(CA, 32'h007f_00f7, 1'b0, "third lane");
		$display("test byte_lanes done");
		xchg(1'b0, 1'b1);
		xchg(1'b1, 1'b0);
		$display("test exchange done");
		end_sim;
	end
endmodule
`default_nettype wire
